// >>> rtl/fcc_bus_cycle.sv
// Purpose: one strobed read or write cycle on the flash pins
// Assumes: pin inputs already synchronised by the caller
// Notes:   ce and oe/we return high between cycles, so status relatches
`timescale 1ns/1ns
module fcc_bus_cycle (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        start,
    input  wire logic        isWrite,
    input  wire logic [23:0] addrIn,
    input  wire logic [7:0]  dataIn,
    input  wire logic [7:0]  dqSync,
    output logic             done,
    output logic [7:0]       dataOut,
    output logic             ceN,
    output logic             oeN,
    output logic             weN,
    output logic [23:0]      flashAddr,
    output logic [7:0]       dqOut,
    output logic             dqOe
);
    // two sync stages plus access time before sampling read data
    localparam logic [3:0] READ_CNT  = 4'(fcc_pkg::ACCESS_CYC + 2);
    localparam logic [3:0] WRITE_CNT = 4'(fcc_pkg::WE_PULSE_CYC);
    logic [3:0] cnt_q;
    logic       busy_q;
    logic       wr_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= 4'h0; busy_q <= 1'b0; wr_q <= 1'b0; done <= 1'b0;
            dataOut <= 8'h00; ceN <= 1'b1; oeN <= 1'b1; weN <= 1'b1;
            flashAddr <= 24'h000000; dqOut <= 8'h00; dqOe <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!busy_q && start) begin
                busy_q <= 1'b1; wr_q <= isWrite; flashAddr <= addrIn;
                dqOut <= dataIn; dqOe <= isWrite; ceN <= 1'b0;
                oeN <= isWrite; weN <= !isWrite;
                cnt_q <= isWrite ? WRITE_CNT : READ_CNT;
            end else if (busy_q) begin
                if (cnt_q != 4'h0) begin
                    cnt_q <= cnt_q - 4'h1;
                end else begin
                    // we, oe and ce rise together, so address and data are taken on that edge [R24] [R19]
                    weN <= 1'b1; oeN <= 1'b1; ceN <= 1'b1;
                    busy_q <= 1'b0; done <= 1'b1;
                    if (!wr_q) dataOut <= dqSync;
                end
            end
            // data stays driven one cycle past the rising we, so the flash sees it held
            if (!busy_q && !start) dqOe <= 1'b0;
        end
    end
endmodule : fcc_bus_cycle

// >>> rtl/fcc_flash_ctrl.sv
// Purpose: host-side flash command controller with Avalon-MM register port
// Assumes: flash pins are asynchronous to clk; rp_n driven low during sys_rst, high (normal level) after
// Notes:   software picks an operation; the block issues the command bytes
// What the document requires of the flash device
// R1: device starts in read-array after power-up
// R2: read-array command holds until next command
// R3: read-array ignored while operation runs
// R4: read commands work at any supply
// R5: identifier addresses give maker, device, master
// R6: block lock state on data bit zero
// R7: identifier mode ends on next valid command
// R8: after read-status, reads return status
// R9: strobe returns high before status relatch
// R10: error flags sticky until clear-status
// R11: 50H clears status at any supply
// R12: clear-status ignored while suspended
// R13: erase one block with setup and confirm
// R14: erase switches reads to status
// R15: completion by ready pin and ready flag
// R16: bad confirm sets program and erase errors
// R17: low supply erase sets supply, erase errors
// R18: locked block erase fails unless elevated
// R19: program setup 40H or 10H then data
// R20: program switches reads to status
// R21: verify flags only failed one-to-zero bits
// R22: low supply program sets supply, erase errors
// R23: single-cycle FFH, 70H, 90H commands
// R24: address, data taken on first rising edge
// R25: ready pin low while machine busy
// R26: ready flag zero while busy
`timescale 1ns/1ns
module fcc_flash_ctrl (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             flashCeN,
    output logic             flashOeN,
    output logic             flashWeN,
    output logic             flashRpN,
    output logic [23:0]      flashAddr,
    output logic [7:0]       flashDqOut,
    output logic             flashDqOe,
    input  wire logic [7:0]  flashDqIn,
    input  wire logic        readyBusyOutput
);
    typedef enum logic [2:0] {
        FCC_IDLE  = 3'b000,
        FCC_CMD1  = 3'b001,
        FCC_CMD2  = 3'b011,
        FCC_POLL  = 3'b010,
        FCC_DONE  = 3'b110
    } fcc_state_t;

    fcc_state_t  state_q, state_d;
    logic [23:0] addr_q;
    logic [7:0]  data_q;
    logic [2:0]  op_q;
    logic [7:0]  result_q;
    logic        busy_q;
    logic        opDone_q;
    logic [7:0]  dqMeta_q, dqSync_q;
    logic        rbMeta_q, rbSync_q;
    logic        cycStart_q;
    logic        cycWrite_q;
    logic [7:0]  cycData_q;
    wire  logic  cycDone;
    wire  logic [7:0] cycResult;

    // pins from the flash pass two flops before use
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dqMeta_q <= 8'h00; dqSync_q <= 8'h00; rbMeta_q <= 1'b1; rbSync_q <= 1'b1;
        end else begin
            dqMeta_q <= flashDqIn; dqSync_q <= dqMeta_q;
            rbMeta_q <= readyBusyOutput; rbSync_q <= rbMeta_q;
        end
    end

    // bus decode; a write lands only at the edge where waitrequest is seen low
    wire logic wrCtrl  = avs_write && !avs_waitrequest && avs_address == fcc_pkg::REG_CTRL && !busy_q;
    wire logic wrAddr  = avs_write && !avs_waitrequest && avs_address == fcc_pkg::REG_ADDR;
    wire logic wrData  = avs_write && !avs_waitrequest && avs_address == fcc_pkg::REG_DATA;
    wire logic [2:0] newOp = avs_writedata[2:0];
    wire logic isTwoCycle = op_q == fcc_pkg::FCC_OP_ERASE || op_q == fcc_pkg::FCC_OP_PROG;
    // first byte of a two-cycle sequence; program always uses the standard setup [R19]
    wire logic [7:0] firstByte = (op_q == fcc_pkg::FCC_OP_ERASE) ? fcc_pkg::CMD_ERASE_SETUP :
                                 (op_q == fcc_pkg::FCC_OP_PROG)  ? fcc_pkg::CMD_PROG_SETUP  : data_q;
    // erase confirm is D0H, program second write carries the data byte [R13]
    wire logic [7:0] secondByte = (op_q == fcc_pkg::FCC_OP_ERASE) ? fcc_pkg::CMD_CONFIRM : data_q;
    // ready flag in status poll, zero while busy [R26] [R15]
    wire logic statusReady = cycResult[fcc_pkg::READY_BIT];

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            FCC_IDLE: if (wrCtrl) state_d = FCC_CMD1;
            FCC_CMD1: if (cycDone) state_d = (op_q == fcc_pkg::FCC_OP_READ || op_q == fcc_pkg::FCC_OP_WRITE)
                                            ? FCC_DONE : (isTwoCycle ? FCC_CMD2 : FCC_POLL);
            FCC_CMD2: if (cycDone) state_d = FCC_POLL;
            // each poll is its own strobe so the status latch refreshes [R9]
            FCC_POLL: if (cycDone && statusReady && rbSync_q) state_d = FCC_DONE;
            FCC_DONE: state_d = FCC_IDLE;
            default:  state_d = FCC_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= FCC_IDLE; op_q <= 3'h0; busy_q <= 1'b0; opDone_q <= 1'b0;
            addr_q <= 24'h000000; data_q <= fcc_pkg::RESET_DATA; result_q <= 8'h00;
            cycStart_q <= 1'b0; cycWrite_q <= 1'b0; cycData_q <= 8'h00;
        end else begin
            state_q <= state_d;
            cycStart_q <= 1'b0;
            if (wrAddr) addr_q <= avs_writedata[23:0];
            if (wrData) data_q <= avs_writedata[7:0];
            if (wrCtrl) begin
                op_q <= newOp; busy_q <= 1'b1; opDone_q <= 1'b0;
            end
            if (state_q == FCC_IDLE && state_d == FCC_CMD1) begin
                cycStart_q <= 1'b1;
                cycWrite_q <= newOp != fcc_pkg::FCC_OP_READ;
                cycData_q  <= newOp == fcc_pkg::FCC_OP_ERASE ? fcc_pkg::CMD_ERASE_SETUP :
                              newOp == fcc_pkg::FCC_OP_PROG  ? fcc_pkg::CMD_PROG_SETUP  :
                              newOp == fcc_pkg::FCC_OP_POLL  ? fcc_pkg::CMD_READ_STATUS : data_q; // [R7]
            end
            if (cycDone && state_q == FCC_CMD1 && isTwoCycle) begin
                cycStart_q <= 1'b1; cycWrite_q <= 1'b1; cycData_q <= secondByte;
            end
            // after a sequence the device returns status at any address [R14] [R20] [R8]
            if (cycDone && (state_q == FCC_CMD2 || (state_q == FCC_CMD1 && op_q == fcc_pkg::FCC_OP_POLL)
                            || (state_q == FCC_POLL && !(statusReady && rbSync_q)))) begin
                cycStart_q <= 1'b1; cycWrite_q <= 1'b0;
            end
            if (cycDone && (state_q == FCC_POLL || state_q == FCC_CMD1)) result_q <= cycResult;
            if (state_q == FCC_DONE) begin
                busy_q <= 1'b0; opDone_q <= 1'b1;
            end
        end
    end

    // registers and waitrequest come from flops; one wait cycle per access
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1; avs_readdata <= 32'h00000000;
        end else begin
            avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
            if (avs_read && avs_waitrequest) begin
                unique case (avs_address)
                    fcc_pkg::REG_ADDR:   avs_readdata <= {8'h00, addr_q};
                    fcc_pkg::REG_DATA:   avs_readdata <= {24'h000000, data_q};
                    fcc_pkg::REG_STATUS: avs_readdata <= {16'h0000, result_q, 5'h00, rbSync_q, opDone_q, busy_q};
                    default:             avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    // normal reset/power-down level keeps locked blocks protected [R18]
    always_ff @(posedge clk) begin
        if (sys_rst) flashRpN <= 1'b0;
        else flashRpN <= 1'b1;
    end

    wire logic [23:0] cycAddr = addr_q;
    fcc_bus_cycle u_cycle (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .start     (cycStart_q),
        .isWrite   (cycWrite_q),
        .addrIn    (cycAddr),
        .dataIn    (cycStart_q && state_q == FCC_IDLE ? firstByte : cycData_q),
        .dqSync    (dqSync_q),
        .done      (cycDone),
        .dataOut   (cycResult),
        .ceN       (flashCeN),
        .oeN       (flashOeN),
        .weN       (flashWeN),
        .flashAddr (flashAddr),
        .dqOut     (flashDqOut),
        .dqOe      (flashDqOe)
    );

    property p_wait_one;
        @(posedge clk) disable iff (sys_rst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest not released"); // [R24]

    property p_no_read_write_overlap;
        @(posedge clk) disable iff (sys_rst)
        !flashOeN |-> flashWeN && !flashDqOe;
    endproperty
    a_no_read_write_overlap: assert property (p_no_read_write_overlap) else $error("oe and we overlap"); // [R24]

    property p_strobe_gap;
        @(posedge clk) disable iff (sys_rst)
        $rose(flashCeN) |=> flashCeN;
    endproperty
    a_strobe_gap: assert property (p_strobe_gap) else $error("ce not high between cycles"); // [R9]

    property p_done_needs_ready;
        @(posedge clk) disable iff (sys_rst)
        state_q == FCC_POLL && state_d == FCC_DONE |-> rbSync_q && cycResult[fcc_pkg::READY_BIT];
    endproperty
    a_done_needs_ready: assert property (p_done_needs_ready) else $error("done while busy"); // [R15]

    property p_erase_confirm;
        @(posedge clk) disable iff (sys_rst)
        state_q == FCC_CMD2 && op_q == fcc_pkg::FCC_OP_ERASE && !flashWeN |-> flashDqOut == fcc_pkg::CMD_CONFIRM;
    endproperty
    a_erase_confirm: assert property (p_erase_confirm) else $error("erase confirm byte wrong"); // [R13]

    property p_program_setup;
        @(posedge clk) disable iff (sys_rst)
        state_q == FCC_CMD1 && op_q == fcc_pkg::FCC_OP_PROG && !flashWeN |-> flashDqOut == fcc_pkg::CMD_PROG_SETUP;
    endproperty
    a_program_setup: assert property (p_program_setup) else $error("program setup byte wrong"); // [R19]
endmodule : fcc_flash_ctrl

// >>> rtl/fcc_pkg.sv
// Purpose: constants for the flash command controller (host side)
// Assumes: byte-wide flash with 24-bit address, strobes active low
// Notes:   register offsets are byte addresses on the Avalon-MM slave
package fcc_pkg;
    // command bytes written on the data lines
    localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_ID     = 8'h90;
    localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
    localparam logic [7:0] CMD_PROG_SETUP  = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT    = 8'h10;
    localparam logic [7:0] ERASED_BYTE     = 8'hFF;
    // identifier addresses
    localparam logic [23:0] ID_MANUF_ADDR  = 24'h000000;
    localparam logic [23:0] ID_DEVICE_ADDR = 24'h000001;
    localparam logic [15:0] ID_BLOCK_LOW   = 16'h0002;
    localparam logic [23:0] ID_MASTER_ADDR = 24'h000003;
    // status register bit positions
    localparam int READY_BIT      = 7;
    localparam int ERASE_ERR_BIT  = 5;
    localparam int PROG_ERR_BIT   = 4;
    localparam int SUPPLY_ERR_BIT = 3;
    localparam int LOCK_ERR_BIT   = 1;
    localparam int LOCKED_BIT     = 0;
    // register map
    localparam logic [3:0] REG_ADDR   = 4'h0;
    localparam logic [3:0] REG_DATA   = 4'h4;
    localparam logic [3:0] REG_CTRL   = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hC;
    // operation codes written to REG_CTRL[2:0]
    typedef enum logic [2:0] {
        FCC_OP_READ  = 3'h0,
        FCC_OP_WRITE = 3'h1,
        FCC_OP_ERASE = 3'h2,
        FCC_OP_PROG  = 3'h3,
        FCC_OP_POLL  = 3'h4
    } fcc_op_t;
    // bus timing, at 25 MHz
    localparam int CLK_NS        = 40;
    localparam int ACCESS_NS     = 120;
    localparam int ACCESS_CYC    = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WE_PULSE_NS   = 50;
    localparam int WE_PULSE_CYC  = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESET_ADDR    = 0;
    localparam logic [7:0] RESET_DATA = 8'h00;
endpackage : fcc_pkg

// >>> test/fcc_flash_ctrl_tb.sv
// Purpose: self-checking bench for the flash command controller
// Assumes: controller on Avalon-MM, behavioural flash on the pins
// Notes:   rows run operations through CTRL, then read STATUS[15:8]
`timescale 1ns/1ns
module fcc_flash_ctrl_tb;
    typedef struct {logic [2:0] op; logic [23:0] adr; logic [7:0] dat; logic vpp; logic chk; logic [7:0] exp;} fcc_row_t;
    logic        clk = 1'b0;
    logic        sysRst = 1'b1;
    logic [3:0]  avsAddress = 4'h0;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [31:0] avsReaddata;
    logic        avsWaitrequest;
    logic        ceN, oeN, weN, rpN, dqOe, readyBusy, vppLow = 1'b0;
    logic [23:0] fAddr;
    logic [7:0]  dqOut, dqIn;
    logic [31:0] rdv;
    int          numErrors = 0;
    int          nTests = 0;
    // op codes: 0 read, 1 write byte, 2 erase, 3 program, 4 poll status
    fcc_row_t rows [] = '{
        '{3'h0, 24'h000010, 8'h00, 1'b0, 1'b1, 8'hFF},
        '{3'h1, 24'h000000, 8'h90, 1'b0, 1'b0, 8'h00},
        '{3'h0, 24'h000000, 8'h00, 1'b0, 1'b1, 8'h3C},
        '{3'h0, 24'h000001, 8'h00, 1'b0, 1'b1, 8'h5E},
        '{3'h0, 24'h010002, 8'h00, 1'b0, 1'b1, 8'h01},
        '{3'h0, 24'h000003, 8'h00, 1'b0, 1'b1, 8'h00},
        '{3'h1, 24'h000000, 8'hFF, 1'b0, 1'b0, 8'h00},
        '{3'h0, 24'h000010, 8'h00, 1'b0, 1'b1, 8'hFF},
        '{3'h3, 24'h000010, 8'h5A, 1'b0, 1'b1, 8'h80},
        '{3'h0, 24'h000020, 8'h00, 1'b0, 1'b1, 8'h80},
        '{3'h1, 24'h000000, 8'hFF, 1'b0, 1'b0, 8'h00},
        '{3'h0, 24'h000010, 8'h00, 1'b0, 1'b1, 8'h5A},
        '{3'h3, 24'h000010, 8'hF0, 1'b0, 1'b1, 8'h80},
        '{3'h1, 24'h000000, 8'hFF, 1'b0, 1'b0, 8'h00},
        '{3'h0, 24'h000010, 8'h00, 1'b0, 1'b1, 8'h50},
        '{3'h2, 24'h000010, 8'h00, 1'b0, 1'b1, 8'h80},
        '{3'h0, 24'h000011, 8'h00, 1'b0, 1'b1, 8'h80},
        '{3'h1, 24'h000000, 8'hFF, 1'b0, 1'b0, 8'h00},
        '{3'h0, 24'h000010, 8'h00, 1'b0, 1'b1, 8'hFF},
        '{3'h2, 24'h010000, 8'h00, 1'b0, 1'b1, 8'hA2},
        '{3'h3, 24'h000020, 8'h00, 1'b1, 1'b1, 8'hAA},
        '{3'h1, 24'h000000, 8'h50, 1'b0, 1'b0, 8'h00},
        '{3'h4, 24'h000000, 8'h00, 1'b0, 1'b1, 8'h80},
        '{3'h2, 24'h000010, 8'h00, 1'b1, 1'b1, 8'hA8},
        '{3'h1, 24'h000000, 8'h50, 1'b1, 1'b0, 8'h00},
        '{3'h4, 24'h000000, 8'h00, 1'b1, 1'b1, 8'h80},
        '{3'h1, 24'h000010, 8'h20, 1'b0, 1'b0, 8'h00},
        '{3'h1, 24'h000010, 8'h00, 1'b0, 1'b0, 8'h00},
        '{3'h1, 24'h000000, 8'hFF, 1'b0, 1'b0, 8'h00},
        '{3'h0, 24'h000010, 8'h00, 1'b0, 1'b1, 8'h30},
        '{3'h4, 24'h000000, 8'h00, 1'b0, 1'b1, 8'hB0},
        '{3'h1, 24'h000000, 8'h50, 1'b0, 1'b0, 8'h00},
        '{3'h1, 24'h000000, 8'h90, 1'b1, 1'b0, 8'h00},
        '{3'h0, 24'h000000, 8'h00, 1'b1, 1'b1, 8'h3C}};
    fcc_flash_ctrl fcc_flash_ctrl_inst (.clk(clk), .sys_rst(sysRst), .avs_address(avsAddress), .avs_read(avsRead),
        .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest), .flashCeN(ceN), .flashOeN(oeN), .flashWeN(weN), .flashRpN(rpN),
        .flashAddr(fAddr), .flashDqOut(dqOut), .flashDqOe(dqOe), .flashDqIn(dqIn), .readyBusyOutput(readyBusy));
    fcc_flash_model fcc_flash_model_inst (.ceN(ceN), .oeN(oeN), .weN(weN), .rpN(rpN), .addr(fAddr),
        .dq(dqOe ? dqOut : ~dqIn), .vppLow(vppLow), .dqOut(dqIn), .readyBusy(readyBusy));
    initial forever #20 clk = ~clk;
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        nTests++;
        if (g !== e) begin
            numErrors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic avXfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWritedata <= d;
        do @(posedge clk); while (avsWaitrequest !== 1'b0);
        q = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask : avXfer
    task automatic runRow(input fcc_row_t r);
        vppLow <= r.vpp;
        avXfer(1'b1, fcc_pkg::REG_ADDR, {8'h00, r.adr}, rdv);
        avXfer(1'b1, fcc_pkg::REG_DATA, {24'h0, r.dat}, rdv);
        avXfer(1'b1, fcc_pkg::REG_CTRL, {29'h0, r.op}, rdv);
        do avXfer(1'b0, fcc_pkg::REG_STATUS, 32'h0, rdv); while (rdv[0] !== 1'b0);
        if (r.chk) check("row byte", {24'h0, r.exp}, {24'h0, rdv[15:8]});
    endtask : runRow
    task automatic reportAndStop;
        if (numErrors == 0 && nTests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : reportAndStop
    initial begin
        repeat (12) @(posedge clk);
        check("reset strobes", 32'h7, {29'h0, ceN, weN, avsWaitrequest});
        check("reset rpN", 32'h0, {31'h0, rpN});
        sysRst <= 1'b0;
        foreach (rows[i]) runRow(rows[i]);
        avXfer(1'b0, 4'h1, 32'h0, rdv);
        check("unmapped read", 32'h0, rdv);
        avXfer(1'b0, fcc_pkg::REG_STATUS, 32'h0, rdv);
        check("ready pin bit", 32'h1, {31'h0, rdv[2]});
        @(posedge clk);
        sysRst <= 1'b1;
        repeat (3) @(posedge clk);
        sysRst <= 1'b0;
        runRow('{3'h0, 24'h000010, 8'h00, 1'b0, 1'b1, 8'hFF});
        reportAndStop();
    end
    initial begin
        #400000;
        numErrors++;
        reportAndStop();
    end
endmodule : fcc_flash_ctrl_tb

// >>> test/fcc_flash_model.sv
// Purpose: behavioural flash device on the far side of the controller
// Assumes: active-low strobes; four 64K blocks, 256 bytes each, higher bits alias
// Notes:   block 1 is locked; a released bus shows the inverse of its last value
`timescale 1ns/1ns
module fcc_flash_model #(
    parameter logic [7:0] MANUF_CODE = 8'h3C, // arbitrary value
    parameter logic [7:0] DEV_CODE   = 8'h5E, // arbitrary value
    parameter int         BUSY_NS    = 4000
) (
    input  wire logic        ceN,
    input  wire logic        oeN,
    input  wire logic        weN,
    input  wire logic        rpN,
    input  wire logic [23:0] addr,
    input  wire logic [7:0]  dq,
    input  wire logic        vppLow,
    output logic [7:0]       dqOut,
    output logic             readyBusy
);
    logic [7:0] mem [0:3][0:255];
    logic [7:0] sr      = 8'h00;
    logic [7:0] srLatch = 8'h80;
    logic [7:0] last    = 8'h00;
    logic [1:0] mode    = 2'h0;
    logic [1:0] pend    = 2'h0;
    logic       busy    = 1'b0;
    logic [7:0] rd;
    wire        rdSel   = !ceN && !oeN;
    wire        wrSel   = !ceN && !weN;
    initial foreach (mem[b, i]) mem[b][i] = 8'hFF;
    assign readyBusy = !busy;
    assign dqOut = rdSel ? rd : ~last;
    always @(negedge rdSel) last = rd;
    always @(negedge rpN) mode = 2'h0;
    always @(posedge rdSel) srLatch = {!busy, sr[6:0]};
    always @* begin
        if (mode == 2'h2) rd = srLatch;
        else if (mode == 2'h0) rd = mem[addr[17:16]][addr[7:0]];
        else if (addr[15:0] == 16'h0002) rd = {7'h00, addr[23:16] == 8'h01};
        else if (addr == 24'h000001) rd = DEV_CODE;
        else if (addr == 24'h000003) rd = 8'h00;
        else rd = MANUF_CODE;
    end
    always @(negedge wrSel) begin
        if (pend != 2'h0) begin
            if (pend == 2'h2 && vppLow) sr = sr | 8'h28;
            else if (pend == 2'h2) mem[addr[17:16]][addr[7:0]] &= dq;
            else if (dq != 8'hD0) sr = sr | 8'h30;
            else if (vppLow) sr = sr | 8'h28;
            else if (addr[23:16] == 8'h01 && rpN) sr = sr | 8'h22;
            else for (int i = 0; i < 256; i++) mem[addr[17:16]][i] = 8'hFF;
            pend = 2'h0;
            mode = 2'h2;
            fork
                begin
                    busy = 1'b1;
                    #(BUSY_NS) busy = 1'b0;
                end
            join_none
        end else if (busy) begin
            if (dq == 8'h70) mode = 2'h2;
        end else case (dq)
            8'hFF: mode = 2'h0;
            8'h90: mode = 2'h1;
            8'h70: mode = 2'h2;
            8'h50: sr = 8'h00;
            8'h20: pend = 2'h1;
            8'h40, 8'h10: pend = 2'h2;
            default: ;
        endcase
    end
endmodule : fcc_flash_model
